// ==== include/clbrc_pkg.sv ====
// shared constants for the cpu local bus ready control block
package clbrc_pkg;

  // kind of cpu cycle reported by the address decoder
  typedef enum logic [1:0] {
    CLBRC_KIND_OTHER = 2'h0,  // no local memory answer from this block
    CLBRC_KIND_DRAM  = 2'h1,  // local-bus dram access
    CLBRC_KIND_CACHE = 2'h2,  // cache access
    CLBRC_KIND_SLOT  = 2'h3   // slot bus access, completed by the other ready
  } clbrc_kind_e;

  localparam int unsigned CLBRC_LANES       = 4;      // byte lanes on the 32-bit data bus
  localparam int unsigned CLBRC_BURST_BEATS = 4;      // doublewords in a full burst
  localparam int unsigned CLBRC_SYNC_STAGES = 2;      // flops in front of every pin input
  localparam int unsigned CLBRC_OE_TAIL_CYC = 1;      // clocks the ready pin stays driven high
  localparam int unsigned CLBRC_BEAT_W      = 2;      // width of the beat counter

  // values after reset
  localparam logic [3:0]  CLBRC_LANES_RST   = 4'hf;   // all lanes enabled
  localparam logic [3:0]  CLBRC_BE_N_RST    = 4'hf;   // byte enables idle high
  localparam logic        CLBRC_PIN_IDLE    = 1'h1;   // active-low pins idle high
  localparam logic [1:0]  CLBRC_BEAT_RST    = 2'h0;   // beat counter start value
  localparam logic [1:0]  CLBRC_LAST_BEAT   = 2'(CLBRC_BURST_BEATS - 1);

endpackage

// ==== rtl/clbrc_sync.sv ====
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module clbrc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  // asynchronous pin level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;  // first stage, read only by the second
  logic [WIDTH-1:0] sync_r;  // second stage

  // both stages reset to the idle level of the pins
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ==== rtl/clbrc_top.sv ====
// cpu local bus ready, byte enable, burst last and address-20 mask control
// Notes on behaviour
// - drive ready pin only low, plus one tail
// - during hold, ready pin is a local-device input
// - byte enables normally received as lane inputs
// - dram reads ignore byte enables, all lanes
// - during hold, drive byte enables for dma lanes
// - burst last input ends a short burst
// - during hold, drive burst last low
// - dma and master cycles never burst
// - provide address bit 20 mask output
// - ready low when read data valid or write taken
// - ready for dram and cache reads, never slot
`timescale 1ns/1ps
`default_nettype none

module clbrc_top
  import clbrc_pkg::*;
#(
  parameter int unsigned LANES = clbrc_pkg::CLBRC_LANES
) (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // cycle information from the address decoder and cache/dram logic
  input  wire logic              cyc_start_i,
  input  wire clbrc_pkg::clbrc_kind_e cyc_kind_i,
  input  wire logic              cyc_write_i,
  input  wire logic              data_ready_i,
  // hold state and dma lane selection from the dma / master logic
  input  wire logic              hold_acknowledge_i,
  input  wire logic              local_dev_sel_i,
  input  wire logic [LANES-1:0]  dma_lanes_i,
  // address-20 mask request from the gate logic
  input  wire logic              a20_mask_req_i,
  // burst ready pin
  input  wire logic              burst_done_n_i,
  output logic                   burst_done_n_o,
  output logic                   burst_done_n_oe_o,
  // byte enable pins
  input  wire logic [LANES-1:0]  byte_en_n_i,
  output logic      [LANES-1:0]  byte_en_n_o,
  output logic                   byte_en_n_oe_o,
  // burst last pin
  input  wire logic              burst_last_n_i,
  output logic                   burst_last_n_o,
  output logic                   burst_last_n_oe_o,
  // address-20 mask pin, active low
  output logic                   a20_mask_n_o,
  // results toward the memory logic
  output logic      [LANES-1:0]  lane_en_o,
  output logic                   burst_end_o,
  output logic                   local_done_o
);

  // states of the ready pin driver
  typedef enum logic [1:0] {
    RDY_IDLE,   // pin released
    RDY_LOW,    // pin driven low, one clock per beat, held across back-to-back beats
    RDY_TAIL    // pin driven high, still enabled
  } clbrc_rdy_e;

  // synchronised pin levels
  logic             done_n_s;    // burst ready as seen during hold
  logic [LANES-1:0] be_n_s;      // cpu byte enables
  logic             last_n_s;    // cpu burst last
  logic             done_n_d_r;  // previous synchronised ready, for edge finding

  // cycle tracking state
  logic                    act_r,     act_nxt;      // a cpu cycle is open
  clbrc_kind_e             kind_r,    kind_nxt;     // kind of the open cycle
  logic                    wr_r,      wr_nxt;       // open cycle is a write
  logic [CLBRC_BEAT_W-1:0] beat_r,    beat_nxt;     // beats done in this burst
  logic                    bend_r,    bend_nxt;     // burst end pulse
  logic [LANES-1:0]        lanes_r,   lanes_nxt;    // lanes used by the memory

  // pin driver state
  clbrc_rdy_e              rdy_r,     rdy_nxt;      // ready driver state
  logic                    rdy_o_r,   rdy_o_nxt;    // ready pin level
  logic                    rdy_oe_r,  rdy_oe_nxt;   // ready pin enable
  logic [LANES-1:0]        be_o_r,    be_o_nxt;     // byte enable pin level
  logic                    be_oe_r,   be_oe_nxt;    // byte enable pin enable
  logic                    last_o_r,  last_o_nxt;   // burst last pin level
  logic                    last_oe_r, last_oe_nxt;  // burst last pin enable
  logic                    a20_r,     a20_nxt;      // address-20 mask pin level
  logic                    ldone_r,   ldone_nxt;    // local device ended a hold cycle

  // helper terms
  logic answer;     // this beat is answered by the ready pin
  logic last_beat;  // this beat closes the burst

  // pin inputs pass two flops before use
  clbrc_sync #(
    .WIDTH   (LANES + 2),
    .RST_VAL ({CLBRC_BE_N_RST, CLBRC_PIN_IDLE, CLBRC_PIN_IDLE})
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    ({byte_en_n_i, burst_done_n_i, burst_last_n_i}),
    .sync_o     ({be_n_s, done_n_s, last_n_s})
  );

  // which beats get a ready answer from this block
  always_comb
  begin
    // only dram accesses and cache reads, never slot cycles
    answer = act_r && data_ready_i && !hold_acknowledge_i &&
             ((kind_r == CLBRC_KIND_DRAM) || ((kind_r == CLBRC_KIND_CACHE) && !wr_r));
    // short burst via burst last, full burst at four beats
    // a hold cycle is always a single access
    last_beat = hold_acknowledge_i || !last_n_s || (beat_r == CLBRC_LAST_BEAT) ||
                (kind_r == CLBRC_KIND_SLOT);
  end

  // cycle tracking: kind, beat count, lanes and burst end
  always_comb
  begin
    act_nxt   = act_r;
    kind_nxt  = kind_r;
    wr_nxt    = wr_r;
    beat_nxt  = beat_r;
    bend_nxt  = 1'b0;
    lanes_nxt = lanes_r;
    if (cyc_start_i)
    begin
      // new cycle opens
      act_nxt  = 1'b1;
      kind_nxt = cyc_kind_i;
      wr_nxt   = cyc_write_i;
      beat_nxt = CLBRC_BEAT_RST;
      // dram reads ignore the byte enables and return every lane
      if ((cyc_kind_i == CLBRC_KIND_DRAM) && !cyc_write_i)
        lanes_nxt = CLBRC_LANES_RST;
      else if (hold_acknowledge_i)
        lanes_nxt = dma_lanes_i;  // lanes chosen by the dma logic
      else
        lanes_nxt = ~be_n_s;      // lanes chosen by the cpu
    end
    else if (act_r && data_ready_i)
    begin
      // one beat completed
      if (last_beat)
      begin
        act_nxt  = 1'b0;
        bend_nxt = 1'b1;  // tell the memory logic to stop the burst
        beat_nxt = CLBRC_BEAT_RST;
      end
      else
      begin
        beat_nxt = beat_r + CLBRC_BEAT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      act_r   <= 1'b0;
      kind_r  <= CLBRC_KIND_OTHER;
      wr_r    <= 1'b0;
      beat_r  <= CLBRC_BEAT_RST;
      bend_r  <= 1'b0;
      lanes_r <= CLBRC_LANES_RST;
    end
    else
    begin
      act_r   <= act_nxt;
      kind_r  <= kind_nxt;
      wr_r    <= wr_nxt;
      beat_r  <= beat_nxt;
      bend_r  <= bend_nxt;
      lanes_r <= lanes_nxt;
    end
  end

  // pin drivers: ready, byte enables, burst last, address-20 mask
  always_comb
  begin
    rdy_nxt     = rdy_r;
    rdy_o_nxt   = CLBRC_PIN_IDLE;
    rdy_oe_nxt  = 1'b0;
    case (rdy_r)
      RDY_IDLE:
      begin
        // enable only when the line must go low
        if (answer)
        begin
          rdy_nxt    = RDY_LOW;
          rdy_o_nxt  = 1'b0;  // read data valid or write taken
          rdy_oe_nxt = 1'b1;
        end
      end
      RDY_LOW:
      begin
        // the cpu took the low sample as this beat's end
        if (answer)
        begin
          rdy_nxt    = RDY_LOW;   // next burst beat back to back
          rdy_o_nxt  = 1'b0;
          rdy_oe_nxt = 1'b1;
        end
        else
        begin
          rdy_nxt    = RDY_TAIL;  // return high, stay driven
          rdy_o_nxt  = 1'b1;
          rdy_oe_nxt = 1'b1;
        end
      end
      RDY_TAIL:
      begin
        if (answer)
        begin
          rdy_nxt    = RDY_LOW;
          rdy_o_nxt  = 1'b0;
          rdy_oe_nxt = 1'b1;
        end
        else
        begin
          rdy_nxt = RDY_IDLE;  // high for one clock, now released
        end
      end
      default:
      begin
        rdy_nxt = RDY_IDLE;
      end
    endcase
    // during hold the ready pin is never driven from here
    if (hold_acknowledge_i)
    begin
      rdy_nxt    = RDY_IDLE;
      rdy_o_nxt  = CLBRC_PIN_IDLE;
      rdy_oe_nxt = 1'b0;
    end
    // byte enables: inputs normally, driven with dma lanes during hold
    be_oe_nxt   = hold_acknowledge_i;
    be_o_nxt    = hold_acknowledge_i ? ~dma_lanes_i : CLBRC_BE_N_RST;
    // burst last: input normally, held low during hold
    last_oe_nxt = hold_acknowledge_i;
    last_o_nxt  = hold_acknowledge_i ? 1'b0 : CLBRC_PIN_IDLE;
    // mask request shown low on the pin
    a20_nxt     = !a20_mask_req_i;
    // falling ready from a selected local device ends the hold cycle
    ldone_nxt   = hold_acknowledge_i && local_dev_sel_i && done_n_d_r && !done_n_s;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rdy_r      <= RDY_IDLE;
      rdy_o_r    <= CLBRC_PIN_IDLE;
      rdy_oe_r   <= 1'b0;
      be_o_r     <= CLBRC_BE_N_RST;
      be_oe_r    <= 1'b0;
      last_o_r   <= CLBRC_PIN_IDLE;
      last_oe_r  <= 1'b0;
      a20_r      <= CLBRC_PIN_IDLE;
      ldone_r    <= 1'b0;
      done_n_d_r <= CLBRC_PIN_IDLE;
    end
    else
    begin
      rdy_r      <= rdy_nxt;
      rdy_o_r    <= rdy_o_nxt;
      rdy_oe_r   <= rdy_oe_nxt;
      be_o_r     <= be_o_nxt;
      be_oe_r    <= be_oe_nxt;
      last_o_r   <= last_o_nxt;
      last_oe_r  <= last_oe_nxt;
      a20_r      <= a20_nxt;
      ldone_r    <= ldone_nxt;
      done_n_d_r <= done_n_s;
    end
  end

  // outputs come straight from flops
  assign burst_done_n_o    = rdy_o_r;
  assign burst_done_n_oe_o = rdy_oe_r;
  assign byte_en_n_o       = be_o_r;
  assign byte_en_n_oe_o    = be_oe_r;
  assign burst_last_n_o    = last_o_r;
  assign burst_last_n_oe_o = last_oe_r;
  assign a20_mask_n_o      = a20_r;
  assign lane_en_o         = lanes_r;
  assign burst_end_o       = bend_r;
  assign local_done_o      = ldone_r;

endmodule

`default_nettype wire

// ==== dv/clbrc_properties.sv ====
// assertion checker for the cpu local bus ready control block
`timescale 1ns/1ps
`default_nettype none
module clbrc_properties
  import clbrc_pkg::*;
#(
  parameter int unsigned LANES = 4
) (
  // clock and reset
  input wire logic                   core_clk_i,
  input wire logic                   sys_rst_i,
  // watched inputs
  input wire logic                   cyc_start_i,
  input wire clbrc_pkg::clbrc_kind_e cyc_kind_i,
  input wire logic                   cyc_write_i,
  input wire logic                   data_ready_i,
  input wire logic                   hold_acknowledge_i,
  input wire logic [LANES-1:0]       dma_lanes_i,
  input wire logic                   a20_mask_req_i,
  input wire logic                   burst_done_n_i,
  // watched outputs
  input wire logic                   burst_done_n_o,
  input wire logic                   burst_done_n_oe_o,
  input wire logic [LANES-1:0]       byte_en_n_o,
  input wire logic                   byte_en_n_oe_o,
  input wire logic                   burst_last_n_o,
  input wire logic                   burst_last_n_oe_o,
  input wire logic                   a20_mask_n_o,
  input wire logic [LANES-1:0]       lane_en_o,
  input wire logic                   local_done_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // driven high only right after a low, and for one clock only
  chk_ready_tail_one: assert property (
    burst_done_n_oe_o && burst_done_n_o |-> $past(burst_done_n_oe_o) && !$past(burst_done_n_o)
    ##1 (!burst_done_n_oe_o || !burst_done_n_o)) else $error("ready tail wrong");
  // a low ready always follows a beat
  chk_ready_low_beat: assert property (
    !burst_done_n_o && burst_done_n_oe_o |-> $past(data_ready_i)) else $error("ready low no beat");
  // ready is an input while hold is up
  chk_hold_no_drive: assert property (
    $past(hold_acknowledge_i) |-> !burst_done_n_oe_o) else $error("ready driven in hold");
  chk_hold_lanes: assert property (
    $past(hold_acknowledge_i) |-> byte_en_n_oe_o && byte_en_n_o == ~$past(dma_lanes_i))
    else $error("hold byte enables wrong");
  chk_hold_last_low: assert property (
    hold_acknowledge_i ##1 hold_acknowledge_i |-> burst_last_n_oe_o && !burst_last_n_o)
    else $error("hold burst last wrong");
  chk_mask_follows: assert property (
    a20_mask_n_o == !$past(a20_mask_req_i)) else $error("mask pin wrong");
  // slot cycles and cache writes get no ready drive
  chk_slot_no_ready: assert property (
    cyc_start_i && !burst_done_n_oe_o && (cyc_kind_i == CLBRC_KIND_SLOT
    || cyc_kind_i == CLBRC_KIND_CACHE && cyc_write_i) |=> !burst_done_n_oe_o [*2])
    else $error("ready driven for slot");
  chk_dram_read_all: assert property (
    cyc_start_i && cyc_kind_i == CLBRC_KIND_DRAM && !cyc_write_i |=> lane_en_o == '1)
    else $error("dram read lanes wrong");
  chk_local_done_src: assert property (
    local_done_o |-> !$past(burst_done_n_i, 3) && $past(hold_acknowledge_i))
    else $error("local done without pull");
  cov_four_beats: cover property ((!burst_done_n_o && burst_done_n_oe_o) [*4]);
  cov_local_done: cover property (local_done_o);
  cov_hold_drive: cover property (byte_en_n_oe_o && !burst_last_n_o);
endmodule
bind clbrc_top clbrc_properties #(.LANES(LANES)) u_clbrc_properties (
  .core_clk_i, .sys_rst_i, .cyc_start_i, .cyc_kind_i, .cyc_write_i, .data_ready_i,
  .hold_acknowledge_i, .dma_lanes_i, .a20_mask_req_i, .burst_done_n_i, .burst_done_n_o,
  .burst_done_n_oe_o, .byte_en_n_o, .byte_en_n_oe_o, .burst_last_n_o, .burst_last_n_oe_o,
  .a20_mask_n_o, .lane_en_o, .local_done_o
);
`default_nettype wire

// ==== dv/clbrc_cpu_model.sv ====
// cpu and local device model on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module clbrc_cpu_model (
  // clock
  input  wire logic       core_clk_i,
  // design pin drivers
  input  wire logic       rdy_o_i,
  input  wire logic       rdy_oe_i,
  input  wire logic [3:0] be_o_i,
  input  wire logic       be_oe_i,
  input  wire logic       last_o_i,
  input  wire logic       last_oe_i,
  // cpu and local device requests
  input  wire logic [3:0] cpu_be_n_i,
  input  wire logic       cpu_last_n_i,
  input  wire logic       dev_pull_i,
  // resolved pins and completions
  output logic            rdy_pin_o,
  output logic [3:0]      be_pin_o,
  output logic            last_pin_o,
  output int              done_cnt_o
);
  // pull-up on ready; a local device pulls low only in hold
  assign rdy_pin_o = rdy_oe_i ? rdy_o_i : !dev_pull_i;
  // cpu floats its lines while the design drives them
  assign be_pin_o = be_oe_i ? be_o_i : cpu_be_n_i;
  assign last_pin_o = last_oe_i ? last_o_i : cpu_last_n_i;
  // a low ready at a rising edge completes a transfer; one process owns the count
  int done_cnt = 0;
  assign done_cnt_o = done_cnt;
  always @(posedge core_clk_i)
    if (!rdy_pin_o)
      done_cnt <= done_cnt + 1;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking testbench for the ready control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clbrc_pkg::*;
  logic clk = 0, rst = 1, start = 0, wr = 0, drdy = 0, hold = 0, sel = 0, a20 = 0;
  logic cpu_last = 1, pull = 0;
  logic [3:0] lanes = 4'h0, cpu_be = 4'hf, be_o, lane, be_pin;
  clbrc_kind_e kind = CLBRC_KIND_OTHER;
  logic rdy_o, rdy_oe, be_oe, last_o, last_oe, a20_n, bend, ldone, rdy_pin, last_pin;
  int done_cnt, err_total = 0, num_checks = 0;
  clbrc_top u_clbrc_top (
    .core_clk_i(clk), .sys_rst_i(rst), .cyc_start_i(start), .cyc_kind_i(kind),
    .cyc_write_i(wr), .data_ready_i(drdy), .hold_acknowledge_i(hold),
    .local_dev_sel_i(sel), .dma_lanes_i(lanes), .a20_mask_req_i(a20),
    .burst_done_n_i(rdy_pin), .burst_done_n_o(rdy_o), .burst_done_n_oe_o(rdy_oe),
    .byte_en_n_i(be_pin), .byte_en_n_o(be_o), .byte_en_n_oe_o(be_oe),
    .burst_last_n_i(last_pin), .burst_last_n_o(last_o), .burst_last_n_oe_o(last_oe),
    .a20_mask_n_o(a20_n), .lane_en_o(lane), .burst_end_o(bend), .local_done_o(ldone));
  clbrc_cpu_model u_clbrc_cpu_model (
    .core_clk_i(clk), .rdy_o_i(rdy_o), .rdy_oe_i(rdy_oe), .be_o_i(be_o), .be_oe_i(be_oe),
    .last_o_i(last_o), .last_oe_i(last_oe), .cpu_be_n_i(cpu_be), .cpu_last_n_i(cpu_last),
    .dev_pull_i(pull), .rdy_pin_o(rdy_pin), .be_pin_o(be_pin), .last_pin_o(last_pin),
    .done_cnt_o(done_cnt));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic open_cyc(input clbrc_kind_e k, input logic w);
    start = 1;
    kind = k;
    wr = w;
    @(negedge clk);
    start = 0;
  endtask
  // every kind, read and write, one beat with burst last low
  task automatic t_kinds;
    logic ans;
    int d0;
    cpu_be = 4'h9;
    cpu_last = 0;
    repeat (3) @(negedge clk);
    d0 = done_cnt;
    for (int i = 0; i < 8; i++)
    begin
      ans = (i[1:0] == 1) || (i[1:0] == 2 && !i[2]);
      open_cyc(clbrc_kind_e'(i[1:0]), i[2]);
      chk(lane, (i[1:0] == 1 && !i[2]) ? 8'hf : 8'h6);
      drdy = 1;
      @(negedge clk);
      drdy = 0;
      chk({rdy_oe, rdy_o}, {ans, !ans});
      if (ans) chk(bend, 1);
      repeat (3) @(negedge clk);
    end
    chk(done_cnt - d0, 3);
    // a beat that lands in the tail drives low again instead of releasing
    open_cyc(CLBRC_KIND_CACHE, 0);
    drdy = 1;
    @(negedge clk);
    drdy = 0;
    open_cyc(CLBRC_KIND_DRAM, 1);
    chk({rdy_oe, rdy_o}, 2'b11);
    drdy = 1;
    @(negedge clk);
    drdy = 0;
    chk({rdy_oe, rdy_o}, 2'b10);
    repeat (3) @(negedge clk);
  endtask
  // full burst of four back-to-back write beats, then the tail
  task automatic t_burst4;
    cpu_be = 4'h0;
    cpu_last = 1;
    repeat (3) @(negedge clk);
    open_cyc(CLBRC_KIND_DRAM, 1);
    drdy = 1;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      if (i == 3) drdy = 0;
      chk({rdy_oe, rdy_o, bend}, {2'b10, i == 3});
    end
    @(negedge clk);
    chk({rdy_oe, rdy_o, bend}, 3'b110);
    @(negedge clk);
    chk(rdy_oe, 0);
  endtask
  // hold: design drives lanes and burst last, local device ends the cycle
  task automatic t_hold;
    hold = 1;
    sel = 0;
    lanes = 4'h3;
    pull = 1;
    @(negedge clk);
    chk({be_oe, be_o, last_oe, last_o}, 7'h72);
    open_cyc(CLBRC_KIND_DRAM, 0);
    drdy = 1;
    @(negedge clk);
    drdy = 0;
    chk({rdy_oe, bend, ldone}, 3'b010);
    pull = 0;
    repeat (3) @(negedge clk);
    sel = 1;
    pull = 1;
    repeat (3) @(negedge clk);
    chk(ldone, 1);
    pull = 0;
    @(negedge clk);
    chk(ldone, 0);
    hold = 0;
    @(negedge clk);
    chk({be_oe, last_oe}, 0);
  endtask
  task automatic t_a20;
    a20 = 1;
    @(negedge clk);
    chk(a20_n, 0);
    a20 = 0;
    @(negedge clk);
    chk(a20_n, 1);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 0;
    chk({rdy_oe, be_oe, last_oe, a20_n}, 4'h1);
    t_kinds;
    t_burst4;
    t_hold;
    t_a20;
    wrap_up;
  end
  // cut a hang short well past the expected run
  initial
  begin
    #20000;
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
